// File: design/sfe_regs.vh
// constants for the serial flash erase and power-down sequencer
`ifndef SFE_REGS_VH
`define SFE_REGS_VH
// command codes
`define SFE_CMD_SECTOR 8'h20
`define SFE_CMD_HALF_BLOCK 8'h52
`define SFE_CMD_BLOCK 8'hd8
`define SFE_CMD_CHIP_A 8'hc7
`define SFE_CMD_CHIP_B 8'h60
`define SFE_CMD_SLEEP 8'hb9
`define SFE_CMD_WAKE 8'hab
`define SFE_CMD_WREN 8'h06
`define SFE_CMD_RDSR 8'h05
// frame lengths in bits
`define SFE_BITS_CMD 6'd8
`define SFE_BITS_ADDR 6'd32
// address field positions
`define SFE_ADDR_MSB 20
`define SFE_SECTOR_LSB 12
`define SFE_HALF_LSB 15
`define SFE_BLOCK_LSB 16
// memory geometry: 512 sectors of 4 KB
`define SFE_SECTORS 512
`define SFE_SECT_W 9
// erase kinds
`define SFE_KIND_SECTOR 2'd0
`define SFE_KIND_HALF 2'd1
`define SFE_KIND_BLOCK 2'd2
`define SFE_KIND_CHIP 2'd3
// timing in microseconds, converted at 125 MHz
`define SFE_CLK_MHZ 125
`define SFE_T_SECTOR_US 45000
`define SFE_T_HALF_US 150000
`define SFE_T_BLOCK_US 250000
`define SFE_T_CHIP_US 10000000
`define SFE_T_SLEEP_US 3
`define SFE_T_WAKE_US 3
`define SFE_T_WAKE_ID_US 5
`define SFE_CNT_W 32
`define SFE_ID_DEFAULT 8'h5a
`endif

// File: design/sfe_sector_map.v
// per-sector erased marker memory with registered read data
`default_nettype none
module sfe_sector_map (
  input wire sys_clk,
  input wire rst_n,
  input wire writeEnable,
  input wire [8:0] writeAddr,
  input wire writeValue,
  input wire [8:0] readAddr,
  output reg readData
);
  reg mem [0:511];

  // memory has no reset; contents start unknown like real cells
  always @(posedge sys_clk) begin
    if (writeEnable) begin
      mem[writeAddr] <= writeValue;
    end
  end

  // registered read port
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      readData <= 1'b0;
    end else begin
      readData <= mem[readAddr];
    end
  end
endmodule
`default_nettype wire

// File: design/sfe_erase_sequencer.v
// erase and power-down command sequencer of a serial flash device
// Notes on behaviour
// R1 - sector erase 20h sets the addressed 4 KB sector to all ones
// R2 - erase commands refused unless the write enable latch is set
// R3 - host sends command byte then 24-bit address, msb first
// R4 - chip select must rise on a byte boundary, else command dropped; asleep, a release frame of any length from eight bits on is taken
// R5 - erase timer starts only at chip select rise after good frame
// R6 - busy flag one during erase, status still readable, zero after; no status read (05h) is decoded, the flag is only an output port
// R7 - write enable latch cleared when any erase completes
// R8 - protected sector or block erase is not executed
// R9 - 52h erases the addressed 32 KB block
// R10 - d8h erases the addressed 64 KB block
// R11 - c7h or 60h erases whole array, no address
// R12 - whole-array erase refused if anything is protected
// R13 - b9h framed correctly enters sleep after entry delay
// R14 - asleep, only the release command is recognised
// R15 - device starts awake after reset
// R16 - release code alone wakes device after wake delay
// R17 - release plus three dummy bytes shifts identifier out msb first
// R18 - identifier repeats while clocked, ends at chip select rise
// R19 - wake with identifier uses the second wake delay
// R20 - release ignored while an erase cycle runs
// R21 - low address bits below erase granularity are ignored
`include "sfe_regs.vh"
`default_nettype none
module sfe_erase_sequencer #(
  parameter [`SFE_CNT_W-1:0] SECTOR_CYCLES =
    `SFE_T_SECTOR_US * `SFE_CLK_MHZ,
  parameter [`SFE_CNT_W-1:0] HALF_CYCLES = `SFE_T_HALF_US * `SFE_CLK_MHZ,
  parameter [`SFE_CNT_W-1:0] BLOCK_CYCLES =
    `SFE_T_BLOCK_US * `SFE_CLK_MHZ,
  parameter [`SFE_CNT_W-1:0] CHIP_CYCLES = `SFE_T_CHIP_US * `SFE_CLK_MHZ,
  parameter [7:0] DEVICE_ID = `SFE_ID_DEFAULT // arbitrary value
) (
  input wire sys_clk,
  input wire rst_n,
  input wire flashCs_n,
  input wire flashSck,
  input wire [3:0] flashDqIn,
  input wire quad_command_mode,
  input wire protect_complement_bit,
  input wire protect_sector_granularity_bit,
  input wire protect_top_bottom_bit,
  input wire [2:0] protect_level_bits,
  input wire [8:0] queryAddr,
  output reg [3:0] flashDqOut,
  output reg [3:0] flashDqOe,
  output reg write_enable_latch,
  output reg operation_in_progress_flag,
  output reg sleepState,
  output reg queryErased
);
  localparam [`SFE_CNT_W-1:0] SLEEP_CYCLES =
    `SFE_T_SLEEP_US * `SFE_CLK_MHZ;
  localparam [`SFE_CNT_W-1:0] WAKE_CYCLES = `SFE_T_WAKE_US * `SFE_CLK_MHZ;
  localparam [`SFE_CNT_W-1:0] WAKE_ID_CYCLES =
    `SFE_T_WAKE_ID_US * `SFE_CLK_MHZ;

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_ERASE = 3'd1;
  localparam [2:0] ST_ENTER = 3'd2;
  localparam [2:0] ST_ASLEEP = 3'd3;
  localparam [2:0] ST_WAKING = 3'd4;
  // state is read by the identifier path, so it is declared up here
  reg [2:0] state;

  // protection test: true when sector s is covered by the settings
  // sector granularity reaches eight sectors at most; the shift is capped
  // at three so the four-bit compare value never wraps to zero
  function prot;
    input [8:0] s;
    input cmp;
    input secBit;
    input tb;
    input [2:0] lvl;
    reg [8:0] idx;
    reg hit;
    begin
      idx = tb ? s : ~s;
      if (lvl == 3'd0) hit = 1'b0;
      else if (secBit) hit = (idx[8:3] == 6'd0) &&
        ({1'b0, idx[2:0]} < (4'd1 << ((lvl > 3'd4) ? 3'd3 : (lvl - 3'd1))));
      else if (lvl == 3'd7) hit = 1'b1;
      else hit = ({1'b0, idx[8:4]} < (6'd1 << (lvl - 3'd1)));
      prot = hit ^ cmp;
    end
  endfunction

  // pins from outside: two flops each before any use
  reg [1:0] csSync;
  reg [1:0] sckSync;
  reg [3:0] dqSync0;
  reg [3:0] dqSync1;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      csSync <= 2'b11;
      sckSync <= 2'b00;
      dqSync0 <= 4'h0;
      dqSync1 <= 4'h0;
    end else begin
      csSync <= {csSync[0], flashCs_n};
      sckSync <= {sckSync[0], flashSck};
      dqSync0 <= flashDqIn;
      dqSync1 <= dqSync0;
    end
  end

  reg csPrev;
  reg sckPrev;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      csPrev <= 1'b1;
      sckPrev <= 1'b0;
    end else begin
      csPrev <= csSync[1];
      sckPrev <= sckSync[1];
    end
  end
  wire csLow = ~csSync[1];
  wire csRise = csSync[1] & ~csPrev;
  wire sckRise = csLow & sckSync[1] & ~sckPrev;
  wire sckFall = csLow & ~sckSync[1] & sckPrev;

  // shifter: quad mode takes a nibble per edge
  reg [31:0] shiftIn;
  reg [5:0] bitCount;
  wire [31:0] next_shiftIn = quad_command_mode ?
    {shiftIn[27:0], dqSync1} : {shiftIn[30:0], dqSync1[0]};
  wire [5:0] step = quad_command_mode ? 6'd4 : 6'd1;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shiftIn <= 32'h0;
      bitCount <= 6'd0;
    end else if (!csLow) begin
      bitCount <= 6'd0;
    end else if (sckRise) begin
      shiftIn <= next_shiftIn; // R3
      if (bitCount != `SFE_BITS_ADDR) bitCount <= bitCount + step;
    end
  end

  // latch the command byte once eight bits are in
  reg [7:0] opcode;
  reg opcodeValid;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      opcode <= 8'h00;
      opcodeValid <= 1'b0;
    end else if (!csLow) begin
      opcodeValid <= 1'b0;
    end else if (sckRise && bitCount + step == `SFE_BITS_CMD) begin
      opcode <= next_shiftIn[7:0];
      opcodeValid <= 1'b1;
    end
  end

  // a frame clocked past the address field fails frameOk, so an
  // over-long erase cannot slip through the saturated bit counter
  reg overrun;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun <= 1'b0;
    end else if (!csLow) begin
      overrun <= 1'b0;
    end else if (sckRise && bitCount == `SFE_BITS_ADDR) begin
      overrun <= 1'b1; // R4
    end
  end

  // identifier output, changes on falling clock edges
  // also runs asleep, where the release code carries the identifier
  reg [2:0] idBit;
  reg idActive;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idBit <= 3'd7;
      idActive <= 1'b0;
      flashDqOut <= 4'h0;
      flashDqOe <= 4'h0;
    end else if (!csLow) begin
      idBit <= 3'd7;
      idActive <= 1'b0;
      flashDqOe <= 4'h0; // R18
    end else if (sckFall && opcodeValid && opcode == `SFE_CMD_WAKE &&
        bitCount == `SFE_BITS_ADDR &&
        (state == ST_IDLE || state == ST_ASLEEP)) begin // R19 R20
      idActive <= 1'b1;
      if (quad_command_mode) begin
        flashDqOut <= idBit[2] ? DEVICE_ID[7:4] : DEVICE_ID[3:0];
        flashDqOe <= 4'hf;
        idBit <= idBit - 3'd4; // R17
      end else begin
        flashDqOut <= {2'b00, DEVICE_ID[idBit], 1'b0};
        flashDqOe <= 4'h2;
        idBit <= idBit - 3'd1; // R18
      end
    end
  end

  // which erase is requested and its target
  reg [1:0] kind;
  reg [8:0] firstSect;
  reg [8:0] lastSect;
  reg blocked;
  reg [8:0] s;
  wire [20:0] addr = shiftIn[`SFE_ADDR_MSB:0];
  always @* begin
    kind = `SFE_KIND_SECTOR;
    firstSect = addr[20:12]; // R21
    lastSect = addr[20:12];
    if (opcode == `SFE_CMD_HALF_BLOCK) begin
      kind = `SFE_KIND_HALF;
      firstSect = {addr[20:15], 3'b000}; // R9
      lastSect = {addr[20:15], 3'b111};
    end else if (opcode == `SFE_CMD_BLOCK) begin
      kind = `SFE_KIND_BLOCK;
      firstSect = {addr[20:16], 4'h0}; // R10
      lastSect = {addr[20:16], 4'hf};
    end else if (opcode == `SFE_CMD_CHIP_A ||
        opcode == `SFE_CMD_CHIP_B) begin
      kind = `SFE_KIND_CHIP; // R11
      firstSect = 9'h000;
      lastSect = 9'h1ff;
    end
    blocked = 1'b0;
    for (s = 9'h000; s != 9'h1ff; s = s + 9'h001) begin
      if (s >= firstSect && s <= lastSect &&
          prot(s, protect_complement_bit, protect_sector_granularity_bit,
          protect_top_bottom_bit, protect_level_bits)) blocked = 1'b1;
    end
    if (prot(9'h1ff, protect_complement_bit,
        protect_sector_granularity_bit, protect_top_bottom_bit,
        protect_level_bits) && lastSect == 9'h1ff) blocked = 1'b1; // R8 R12
  end

  wire isAddrErase = opcode == `SFE_CMD_SECTOR ||
    opcode == `SFE_CMD_HALF_BLOCK || opcode == `SFE_CMD_BLOCK;
  wire isChip = opcode == `SFE_CMD_CHIP_A || opcode == `SFE_CMD_CHIP_B;
  // framing exact: addressed erase needs 32 bits, others exactly 8
  wire frameOk = opcodeValid && !overrun && (isAddrErase ?
    bitCount == `SFE_BITS_ADDR : bitCount == `SFE_BITS_CMD); // R4
  wire eraseGo = csRise && frameOk && (isAddrErase || isChip) &&
    write_enable_latch && !blocked; // R2 R5

  // main sequencer
  reg [`SFE_CNT_W-1:0] timer;
  reg [8:0] curSect;
  reg [8:0] endSect;
  reg wipeNow;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE; // R15
      timer <= {`SFE_CNT_W{1'b0}};
      curSect <= 9'h000;
      endSect <= 9'h000;
      wipeNow <= 1'b0;
      write_enable_latch <= 1'b0;
      operation_in_progress_flag <= 1'b0;
      sleepState <= 1'b0;
    end else begin
      wipeNow <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (eraseGo) begin
            state <= ST_ERASE;
            operation_in_progress_flag <= 1'b1; // R6
            curSect <= firstSect;
            endSect <= lastSect;
            case (kind)
              `SFE_KIND_SECTOR: timer <= SECTOR_CYCLES;
              `SFE_KIND_HALF: timer <= HALF_CYCLES;
              `SFE_KIND_BLOCK: timer <= BLOCK_CYCLES;
              default: timer <= CHIP_CYCLES;
            endcase
          end else if (csRise && frameOk && opcode == `SFE_CMD_WREN) begin
            write_enable_latch <= 1'b1;
          end else if (csRise && frameOk && opcode == `SFE_CMD_SLEEP) begin
            state <= ST_ENTER; // R13
            timer <= SLEEP_CYCLES;
          end
        end
        ST_ERASE: begin
          // one sector marked per cycle; the default and bench busy times outlast the walk
          // limitation: a busy time under 513 cycles cuts a chip walk short
          if (curSect != endSect || !wipeNow) begin
            wipeNow <= 1'b1;
            if (wipeNow && curSect != endSect) curSect <= curSect + 9'h001;
          end
          if (timer <= 1) begin
            state <= ST_IDLE;
            operation_in_progress_flag <= 1'b0; // R6
            write_enable_latch <= 1'b0; // R7
          end else begin
            timer <= timer - 1'b1; // R20
          end
        end
        ST_ENTER: begin
          if (timer <= 1) begin
            state <= ST_ASLEEP;
            sleepState <= 1'b1;
          end else begin
            timer <= timer - 1'b1;
          end
        end
        ST_ASLEEP: begin
          // only the release code counts here
          if (csRise && opcodeValid && opcode == `SFE_CMD_WAKE) begin // R14
            state <= ST_WAKING;
            timer <= (bitCount == `SFE_BITS_CMD) ? WAKE_CYCLES :
              WAKE_ID_CYCLES; // R16 R19
          end
        end
        ST_WAKING: begin
          if (timer <= 1) begin
            state <= ST_IDLE;
            sleepState <= 1'b0;
          end else begin
            timer <= timer - 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // erased markers: a set entry means every byte in that sector is ones
  wire mapWrite = wipeNow && state == ST_ERASE;
  wire mapReadData;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) queryErased <= 1'b0;
    else queryErased <= mapReadData; // R1
  end

  sfe_sector_map map (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .writeEnable(mapWrite),
    .writeAddr(curSect),
    .writeValue(1'b1),
    .readAddr(queryAddr),
    .readData(mapReadData)
  );
endmodule
`default_nettype wire

// File: bench/sfe_checker_assertions.sv
// port checker for the erase and power-down sequencer
`default_nettype none
module sfe_checker #(
  parameter [31:0] SECTOR_CYCLES = 32'd200
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic flashCs_n,
  input wire logic quad_command_mode,
  input wire logic [3:0] flashDqOe,
  input wire logic write_enable_latch,
  input wire logic operation_in_progress_flag,
  input wire logic sleepState
);
  logic [31:0] busyCnt;
  // length of the running busy period; slack of two for edge alignment
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) busyCnt <= 32'h0;
    else if (operation_in_progress_flag) busyCnt <= busyCnt + 32'h1;
    else busyCnt <= 32'h0;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_busy_after_cs: assert property (
    $rose(operation_in_progress_flag) |-> flashCs_n && write_enable_latch)
    else $error("busy started without a closed enabled frame");
  chk_busy_min_len: assert property (
    $fell(operation_in_progress_flag) |-> busyCnt + 32'h2 >= SECTOR_CYCLES)
    else $error("busy period shorter than the shortest erase");
  chk_latch_held_busy: assert property (
    operation_in_progress_flag |-> write_enable_latch)
    else $error("latch dropped while erase still running");
  chk_latch_clear_end: assert property (
    $fell(operation_in_progress_flag) |-> !write_enable_latch)
    else $error("latch still set after erase end");
  chk_sleep_enter_idle: assert property (
    $rose(sleepState) |-> flashCs_n && !operation_in_progress_flag)
    else $error("sleep entered inside a frame or while busy");
  chk_sleep_latch_still: assert property (
    sleepState && $past(sleepState) |-> $stable(write_enable_latch))
    else $error("latch changed while asleep");
  chk_wake_cs_high: assert property (
    $fell(sleepState) |-> flashCs_n ##1 !sleepState)
    else $error("wake not with chip select high");
  chk_idle_no_drive: assert property (
    flashCs_n [*6] |-> flashDqOe == 4'h0)
    else $error("data driven with chip select high");
  chk_single_id_pin: assert property (
    !quad_command_mode && flashDqOe != 4'h0 |-> flashDqOe == 4'h2)
    else $error("single mode drives a wrong data pin");
  chk_quad_id_pins: assert property (
    quad_command_mode && flashDqOe != 4'h0 |-> flashDqOe == 4'hf)
    else $error("quad mode drives a partial data bus");
  chk_busy_no_id: assert property (
    operation_in_progress_flag |-> flashDqOe == 4'h0)
    else $error("identifier driven while an erase runs");
endmodule
bind sfe_erase_sequencer sfe_checker #(.SECTOR_CYCLES(SECTOR_CYCLES)) chk_u (
  .sys_clk(sys_clk), .rst_n(rst_n), .flashCs_n(flashCs_n),
  .quad_command_mode(quad_command_mode), .flashDqOe(flashDqOe),
  .write_enable_latch(write_enable_latch),
  .operation_in_progress_flag(operation_in_progress_flag),
  .sleepState(sleepState));
`default_nettype wire

// File: bench/sfe_host_model.sv
// host serial controller model driving the flash pins
`default_nettype none
module sfe_host_model (
  input wire logic sys_clk,
  input wire logic quadMode,
  input wire logic [3:0] flashDqOut,
  input wire logic [3:0] flashDqOe,
  output var logic flashCs_n,
  output var logic flashSck,
  output var logic [3:0] flashDqIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // link clock stands low outside frames
  initial begin
    flashCs_n = 1'b1;
    flashSck = 1'b0;
    flashDqIn = 4'h0;
  end
  // nBits sent msb first, then nRd bits read mid high phase;
  // quad mode moves a nibble per clock, released pins read as pulled up
  task automatic frame(input logic [31:0] w, input int nBits,
      input int nRd, output logic [15:0] rd);
    int st;
    rd = 16'h0;
    st = quadMode ? 4 : 1;
    @(negedge sys_clk) flashCs_n = 1'b0;
    for (int i = 0; i < nBits + nRd; i += st) begin
      if (i < nBits && quadMode) flashDqIn = w[31 - i -: 4];
      if (i < nBits && !quadMode) flashDqIn[0] = w[31 - i];
      repeat (4) @(negedge sys_clk);
      flashSck = 1'b1;
      repeat (2) @(negedge sys_clk);
      if (i >= nBits && quadMode)
        rd = {rd[11:0], flashDqOut | ~flashDqOe};
      if (i >= nBits && !quadMode)
        rd = {rd[14:0], flashDqOut[1] | ~flashDqOe[1]};
      repeat (2) @(negedge sys_clk);
      flashSck = 1'b0;
    end
    repeat (4) @(negedge sys_clk);
    flashCs_n = 1'b1;
    flashDqIn = ~flashDqIn; // released line must not look held
    repeat (8) @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

// File: bench/sfe_erase_sequencer_bench.sv
// self-checking bench for the erase and power-down sequencer
`default_nettype none
`define SFE_CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module sfe_erase_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] DEV_ID = 8'h3c; // arbitrary value
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cplBit = 1'b0;
  logic granBit = 1'b0;
  logic topBit = 1'b0;
  logic [2:0] lvl = 3'h0;
  logic quadMode = 1'b0;
  logic [8:0] queryAddr = 9'h0;
  logic [15:0] rd;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int tick = 0;
  wire flashCs_n, flashSck, queryErased, sleepState;
  wire write_enable_latch, operation_in_progress_flag;
  wire [3:0] flashDqIn, flashDqOut, flashDqOe;
  sfe_host_model host_u (.sys_clk(sys_clk), .quadMode(quadMode),
    .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .flashCs_n(flashCs_n),
    .flashSck(flashSck), .flashDqIn(flashDqIn));
  sfe_erase_sequencer #(.SECTOR_CYCLES(32'd200), .HALF_CYCLES(32'd300),
    .BLOCK_CYCLES(32'd400), .CHIP_CYCLES(32'd600), .DEVICE_ID(DEV_ID)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .flashCs_n(flashCs_n),
    .flashSck(flashSck), .flashDqIn(flashDqIn), .quad_command_mode(quadMode),
    .protect_complement_bit(cplBit), .protect_sector_granularity_bit(granBit),
    .protect_top_bottom_bit(topBit), .protect_level_bits(lvl),
    .queryAddr(queryAddr), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe),
    .write_enable_latch(write_enable_latch),
    .operation_in_progress_flag(operation_in_progress_flag),
    .sleepState(sleepState), .queryErased(queryErased));
  // clock, and a cycle ceiling well above the whole sequence
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    tick++;
    if (tick == 40000) begin
      err_total++;
      give_verdict;
    end
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic send(input logic [31:0] w, input int n);
    host_u.frame(w, n, 0, rd);
  endtask
  task automatic secChk(input logic [8:0] s);
    queryAddr = s;
    repeat (3) @(negedge sys_clk);
    `SFE_CHK(queryErased, 1'b1)
  endtask
  // enabled erase that must run, end, and clear the latch
  task automatic eraseOk(input logic [7:0] op, input logic [23:0] a,
      input int n, input logic [8:0] s0, input logic [8:0] s1);
    send(32'h06000000, 8);
    send({op, a}, n);
    `SFE_CHK(operation_in_progress_flag, 1'b1)
    `SFE_CHK(write_enable_latch, 1'b1)
    for (cyc = 0; cyc < 1000 && operation_in_progress_flag; cyc++)
      @(negedge sys_clk);
    `SFE_CHK(cyc > 100 && cyc < 1000, 1'b1)
    `SFE_CHK(write_enable_latch, 1'b0)
    secChk(s0);
    secChk(s1);
  endtask
  // frame that must leave the device idle
  task automatic refuse(input logic [7:0] op, input int n, input logic en);
    if (en) send(32'h06000000, 8);
    host_u.frame({op, 24'h001000}, (n > 32) ? 32 : n, (n > 32) ? n - 32 : 0,
      rd);
    repeat (20) @(negedge sys_clk);
    `SFE_CHK(operation_in_progress_flag, 1'b0)
  endtask
  task automatic runErases;
    eraseOk(8'h20, 24'h003abc, 32, 9'd3, 9'd3);
    eraseOk(8'h52, 24'h008123, 32, 9'd8, 9'd15);
    eraseOk(8'hd8, 24'h021fff, 32, 9'd32, 9'd47);
    eraseOk(8'hc7, 24'h0, 8, 9'd100, 9'd300);
    eraseOk(8'h60, 24'h0, 8, 9'd0, 9'd511);
  endtask
  task automatic runRefusals;
    refuse(8'h20, 32, 1'b0);
    refuse(8'h20, 31, 1'b1);
    refuse(8'h60, 9, 1'b1);
    refuse(8'h20, 40, 1'b1);
    lvl = 3'h7;
    refuse(8'h20, 32, 1'b1);
    topBit = 1'b1;
    refuse(8'hd8, 32, 1'b1);
    lvl = 3'h1;
    refuse(8'hc7, 8, 1'b1);
    lvl = 3'h0;
  endtask
  // sleep, an ignored write enable, plain wake and identifier wake
  task automatic runSleep;
    int wake1;
    send(32'hb9000000, 8);
    for (cyc = 0; cyc < 1000 && sleepState !== 1'b1; cyc++)
      @(negedge sys_clk);
    `SFE_CHK(sleepState, 1'b1)
    send(32'h06000000, 8);
    `SFE_CHK(write_enable_latch, 1'b0)
    send(32'hab000000, 8);
    for (cyc = 0; cyc < 1000 && sleepState; cyc++) @(negedge sys_clk);
    `SFE_CHK(sleepState, 1'b0)
    wake1 = cyc;
    repeat (400) @(negedge sys_clk);
    host_u.frame(32'hab000000, 32, 16, rd);
    `SFE_CHK(rd, {DEV_ID, DEV_ID})
    `SFE_CHK(flashDqOe, 4'h0)
    send(32'hb9000000, 8);
    repeat (500) @(negedge sys_clk);
    `SFE_CHK(sleepState, 1'b1)
    host_u.frame(32'hab000000, 32, 8, rd);
    `SFE_CHK(rd, {8'h00, DEV_ID})
    for (cyc = 0; cyc < 1000 && sleepState; cyc++) @(negedge sys_clk);
    `SFE_CHK(sleepState, 1'b0)
    `SFE_CHK(cyc > wake1, 1'b1)
    repeat (400) @(negedge sys_clk);
  endtask
  // release command in mid erase must change nothing
  task automatic runBusyWake;
    send(32'h06000000, 8);
    send(32'hc7000000, 8);
    host_u.frame(32'hab000000, 32, 8, rd);
    `SFE_CHK(rd, 16'h00ff)
    `SFE_CHK(operation_in_progress_flag, 1'b1)
    for (cyc = 0; cyc < 1000 && operation_in_progress_flag; cyc++)
      @(negedge sys_clk);
    `SFE_CHK(write_enable_latch, 1'b0)
  endtask
  // quad command mode: nibble-wide sector erase and identifier read
  task automatic runQuad;
    quadMode = 1'b1;
    eraseOk(8'h20, 24'h0c8abc, 32, 9'd200, 9'd200);
    host_u.frame(32'hab000000, 32, 16, rd);
    `SFE_CHK(rd, {DEV_ID, DEV_ID})
    `SFE_CHK(flashDqOe, 4'h0)
    quadMode = 1'b0;
  endtask
  initial begin
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    `SFE_CHK(sleepState, 1'b0)
    runRefusals;
    runQuad;
    runErases;
    runSleep;
    runBusyWake;
    give_verdict;
  end
endmodule
`default_nettype wire
